// >>> inc/cmad_consts.svh
// constants for the move and arithmetic datapath
// Summary of operation
// - register file in byte, word, long views
// - long registers serve as data or pointer
// - flags N, Z, V, C used and updated
// - 3, 8, 16, 24-bit immediate fields supported
// - move: reg, memory, immediate, any size
// - peripheral-synchronised byte moves are absent
// - pop reads at pointer then post-increments
// - push pre-decrements pointer then writes
// - add/sub sizes; no byte immediate subtract
// - carry add/borrow subtract, byte only
// - step by 1 or 2; byte by 1
// - address adjust 1, 2, 4 on long
// - BCD fix of byte using flags
// - unsigned multiply 8x8 or 16x16
// - signed multiply 8x8 or 16x16
// - size designation selects operand width
`ifndef CMAD_CONSTS_SVH
`define CMAD_CONSTS_SVH
`define CMAD_SP_IDX 3'h7
`define CMAD_FLAG_N 3
`define CMAD_FLAG_Z 2
`define CMAD_FLAG_V 1
`define CMAD_FLAG_C 0
`define CMAD_FLAGS_RST 4'h0
`define CMAD_REG_RST 32'h00000000
`define CMAD_SZ_B_BYTES 32'h00000001
`define CMAD_SZ_W_BYTES 32'h00000002
`define CMAD_SZ_L_BYTES 32'h00000004
`endif

// >>> inc/cmad_pkg.sv
// types for the move and arithmetic datapath
package cmad_pkg;
	typedef enum logic [1:0] {
		CMAD_SZ_B = 2'h0,
		CMAD_SZ_W = 2'h1,
		CMAD_SZ_L = 2'h2
	} cmad_size_t;
	typedef enum logic [1:0] {
		CMAD_IMM3  = 2'h0,
		CMAD_IMM8  = 2'h1,
		CMAD_IMM16 = 2'h2,
		CMAD_IMM24 = 2'h3
	} cmad_imm_len_t;
	typedef enum logic [4:0] {
		CMAD_OP_NOP      = 5'h00,
		CMAD_OP_MOV      = 5'h01,
		CMAD_OP_MOV_LD   = 5'h02,
		CMAD_OP_MOV_ST   = 5'h03,
		CMAD_OP_POP      = 5'h04,
		CMAD_OP_PUSH     = 5'h05,
		CMAD_OP_ADD      = 5'h06,
		CMAD_OP_SUB      = 5'h07,
		CMAD_OP_ADDC     = 5'h08,
		CMAD_OP_SUBC     = 5'h09,
		CMAD_OP_INC      = 5'h0A,
		CMAD_OP_DEC      = 5'h0B,
		CMAD_OP_ADDA     = 5'h0C,
		CMAD_OP_SUBA     = 5'h0D,
		CMAD_OP_BCDA     = 5'h0E,
		CMAD_OP_BCDS     = 5'h0F,
		CMAD_OP_MULU     = 5'h10,
		CMAD_OP_MULS     = 5'h11,
		CMAD_OP_PSYNC_IN = 5'h12,
		CMAD_OP_PSYNC_OUT = 5'h13
	} cmad_op_t;
	typedef enum logic [1:0] {
		CMAD_ST_IDLE  = 2'h0,
		CMAD_ST_MEM   = 2'h1,
		CMAD_ST_WRITE = 2'h2
	} cmad_state_t;
endpackage

// >>> hw/cmad_addsub.sv
// sized adder/subtractor with flag generation
`timescale 1ns/100ps
`default_nettype none
`include "cmad_consts.svh"
module cmad_addsub (
	input  wire logic              [31:0] i_a,
	input  wire logic              [31:0] i_b,
	input  wire logic                     i_cin,
	input  wire logic                     i_sub,
	input  wire cmad_pkg::cmad_size_t     i_size,
	output logic                   [31:0] o_res,
	output logic                   [3:0]  o_flags
);
	logic [32:0] sum;
	logic [31:0] b_eff;
	logic        msb_a;
	logic        msb_b;
	logic        msb_r;
	logic        cy;
	always_comb begin
		b_eff = i_sub ? ~i_b : i_b;
		sum = {1'b0, i_a} + {1'b0, b_eff} + {32'h0, i_cin ^ i_sub};
		o_res = sum[31:0];
		msb_a = i_a[31];
		msb_b = b_eff[31];
		msb_r = sum[31];
		cy = sum[32];
		// width chosen by size designation
		unique case (i_size)
			cmad_pkg::CMAD_SZ_B: begin
				o_res = {24'h0, sum[7:0]};
				msb_a = i_a[7];
				msb_b = b_eff[7];
				msb_r = sum[7];
				cy = sum[8] ^ i_a[8] ^ b_eff[8];
			end
			cmad_pkg::CMAD_SZ_W: begin
				o_res = {16'h0, sum[15:0]};
				msb_a = i_a[15];
				msb_b = b_eff[15];
				msb_r = sum[15];
				cy = sum[16] ^ i_a[16] ^ b_eff[16];
			end
			default: begin
				o_res = sum[31:0];
			end
		endcase
		o_flags[`CMAD_FLAG_N] = msb_r;
		o_flags[`CMAD_FLAG_Z] = (o_res == 32'h0);
		o_flags[`CMAD_FLAG_V] = (msb_a == msb_b) && (msb_r != msb_a);
		o_flags[`CMAD_FLAG_C] = cy ^ i_sub;
	end
endmodule
`default_nettype wire

// >>> hw/cmad_core.sv
// move and arithmetic execution datapath with register file
`timescale 1ns/100ps
`default_nettype none
`include "cmad_consts.svh"
module cmad_core (
	input  wire logic                        i_clk,
	input  wire logic                        i_nrst,
	input  wire logic                        i_ce,
	input  wire logic                        i_start,
	input  wire cmad_pkg::cmad_op_t          i_op,
	input  wire cmad_pkg::cmad_size_t        i_size,
	input  wire logic                 [3:0]  i_rd,
	input  wire logic                 [3:0]  i_rs,
	input  wire logic                 [23:0] i_imm,
	input  wire cmad_pkg::cmad_imm_len_t     i_imm_len,
	input  wire logic                        i_use_imm,
	input  wire logic                 [1:0]  i_step,
	input  wire logic                        i_mem_ack,
	input  wire logic                 [31:0] i_mem_rdata,
	output logic                             o_busy,
	output logic                             o_done,
	output logic                             o_illegal,
	output logic                             o_mem_req,
	output logic                             o_mem_we,
	output logic                      [31:0] o_mem_addr,
	output logic                      [31:0] o_mem_wdata,
	output cmad_pkg::cmad_size_t             o_mem_size,
	output logic                      [3:0]  o_flags,
	output logic                      [31:0] o_sp
);
	// eight 32-bit registers; halves and bytes are views
	logic [31:0]            regs_q [8];
	logic [3:0]             flags_q;
	cmad_pkg::cmad_state_t  state_q;
	cmad_pkg::cmad_op_t     op_q;
	cmad_pkg::cmad_size_t   size_q;
	logic [3:0]             rd_q;
	logic [3:0]             rs_q;
	logic [31:0]            addr_q;
	logic [31:0]            sp_new_q;
	logic                   done_q;
	logic                   illegal_q;
	logic                   mem_req_q;
	logic                   mem_we_q;
	logic [31:0]            mem_wdata_q;

	// read a sized view; idx[3] selects the high byte or extended word
	function automatic logic [31:0] view_rd(input logic [3:0] idx,
			input cmad_pkg::cmad_size_t sz, input logic [31:0] r);
		logic [31:0] v;
		v = r;
		unique case (sz)
			cmad_pkg::CMAD_SZ_B: v = {24'h0, idx[3] ? r[15:8] : r[7:0]};
			cmad_pkg::CMAD_SZ_W: v = {16'h0, idx[3] ? r[31:16] : r[15:0]};
			default: v = r;
		endcase
		return v;
	endfunction

	// merge a sized value into its register
	function automatic logic [31:0] view_wr(input logic [3:0] idx,
			input cmad_pkg::cmad_size_t sz, input logic [31:0] r,
			input logic [31:0] val);
		logic [31:0] v;
		v = r;
		unique case (sz)
			cmad_pkg::CMAD_SZ_B:
				if (idx[3]) v = {r[31:16], val[7:0], r[7:0]};
				else v = {r[31:8], val[7:0]};
			cmad_pkg::CMAD_SZ_W:
				if (idx[3]) v = {val[15:0], r[15:0]};
				else v = {r[31:16], val[15:0]};
			default: v = val;
		endcase
		return v;
	endfunction

	function automatic logic [31:0] size_bytes(
			input cmad_pkg::cmad_size_t sz);
		logic [31:0] n;
		n = `CMAD_SZ_L_BYTES;
		if (sz == cmad_pkg::CMAD_SZ_W) n = `CMAD_SZ_W_BYTES;
		else if (sz == cmad_pkg::CMAD_SZ_B) n = `CMAD_SZ_B_BYTES;
		return n;
	endfunction

	logic [31:0] rd_raw;
	logic [31:0] rs_raw;
	logic [31:0] rd_val;
	logic [31:0] rs_val;
	logic [31:0] imm_val;
	logic [31:0] src_b;
	logic [31:0] sp_val;
	assign rd_raw = regs_q[i_rd[2:0]];
	assign rs_raw = regs_q[i_rs[2:0]];
	assign rd_val = view_rd(i_rd, i_size, rd_raw);
	// long view of any register may act as a pointer
	assign rs_val = view_rd(i_rs, i_size, rs_raw);
	assign sp_val = regs_q[`CMAD_SP_IDX];

	// immediate field by length, 3-bit zero extended
	always_comb begin
		unique case (i_imm_len)
			cmad_pkg::CMAD_IMM3:  imm_val = {29'h0, i_imm[2:0]};
			cmad_pkg::CMAD_IMM8:  imm_val = {24'h0, i_imm[7:0]};
			cmad_pkg::CMAD_IMM16: imm_val = {16'h0, i_imm[15:0]};
			default:              imm_val = {8'h0, i_imm};
		endcase
	end
	assign src_b = i_use_imm ? imm_val : rs_val;

	// step constant and operand choice for the shared adder
	logic [31:0] step_val;
	logic [31:0] alu_b;
	logic        alu_sub;
	logic        alu_cin;
	logic [31:0] alu_res;
	logic [3:0]  alu_flags;
	always_comb begin
		step_val = 32'h1;
		if (i_step == 2'h1) step_val = 32'h2;
		else if (i_step == 2'h2) step_val = 32'h4;
		alu_b = src_b;
		alu_sub = 1'b0;
		alu_cin = 1'b0;
		unique case (i_op)
			cmad_pkg::CMAD_OP_SUB: alu_sub = 1'b1;
			cmad_pkg::CMAD_OP_ADDC: alu_cin = flags_q[`CMAD_FLAG_C];
			cmad_pkg::CMAD_OP_SUBC: begin
				alu_sub = 1'b1;
				alu_cin = flags_q[`CMAD_FLAG_C];
			end
			cmad_pkg::CMAD_OP_INC, cmad_pkg::CMAD_OP_ADDA: alu_b = step_val;
			cmad_pkg::CMAD_OP_DEC, cmad_pkg::CMAD_OP_SUBA: begin
				alu_b = step_val;
				alu_sub = 1'b1;
			end
			default: alu_b = src_b;
		endcase
	end

	cmad_addsub u_addsub (
		.i_a     (rd_val),
		.i_b     (alu_b),
		.i_cin   (alu_cin),
		.i_sub   (alu_sub),
		.i_size  (i_size),
		.o_res   (alu_res),
		.o_flags (alu_flags)
	);

	// legality of operation and size combinations
	logic legal;
	always_comb begin
		legal = 1'b1;
		unique case (i_op)
			// no byte immediate subtract
			cmad_pkg::CMAD_OP_SUB:
				legal = !(i_use_imm && i_size == cmad_pkg::CMAD_SZ_B);
			// byte only
			cmad_pkg::CMAD_OP_ADDC, cmad_pkg::CMAD_OP_SUBC,
			cmad_pkg::CMAD_OP_BCDA, cmad_pkg::CMAD_OP_BCDS:
				legal = (i_size == cmad_pkg::CMAD_SZ_B);
			// byte registers step by 1 only
			cmad_pkg::CMAD_OP_INC, cmad_pkg::CMAD_OP_DEC:
				legal = (i_step == 2'h0) || (i_step == 2'h1 &&
					i_size != cmad_pkg::CMAD_SZ_B);
			// long only, steps 1, 2, 4
			cmad_pkg::CMAD_OP_ADDA, cmad_pkg::CMAD_OP_SUBA:
				legal = (i_size == cmad_pkg::CMAD_SZ_L) && (i_step != 2'h3);
			cmad_pkg::CMAD_OP_POP, cmad_pkg::CMAD_OP_PUSH:
				legal = (i_size != cmad_pkg::CMAD_SZ_B);
			cmad_pkg::CMAD_OP_MULU, cmad_pkg::CMAD_OP_MULS:
				legal = (i_size != cmad_pkg::CMAD_SZ_L);
			// peripheral-synchronised moves absent
			cmad_pkg::CMAD_OP_PSYNC_IN, cmad_pkg::CMAD_OP_PSYNC_OUT,
			cmad_pkg::CMAD_OP_NOP:
				legal = 1'b0;
			default: legal = 1'b1;
		endcase
	end

	// decimal adjust from prior carry and digit values
	logic [7:0] bcd_res;
	logic       bcd_c;
	logic [7:0] bcd_corr;
	always_comb begin
		bcd_corr = 8'h00;
		bcd_c = flags_q[`CMAD_FLAG_C];
		if (i_op == cmad_pkg::CMAD_OP_BCDA) begin
			if (rd_val[3:0] > 4'h9) bcd_corr[3:0] = 4'h6;
			if (flags_q[`CMAD_FLAG_C] || rd_val[7:0] > 8'h99) begin
				bcd_corr[7:4] = 4'h6;
				bcd_c = 1'b1;
			end
			bcd_res = rd_val[7:0] + bcd_corr;
		end else begin
			if (rd_val[3:0] > 4'h9) bcd_corr[3:0] = 4'h6;
			if (flags_q[`CMAD_FLAG_C]) bcd_corr[7:4] = 4'h6;
			bcd_res = rd_val[7:0] - bcd_corr;
		end
	end

	// multiply into double-width view
	logic [31:0] mul_res;
	always_comb begin
		mul_res = 32'h0;
		if (i_size == cmad_pkg::CMAD_SZ_B) begin
			if (i_op == cmad_pkg::CMAD_OP_MULS)
				mul_res = {16'h0, 16'($signed(rd_val[7:0]) *
					$signed(rs_val[7:0]))};
			else
				mul_res = {16'h0, 16'(rd_val[7:0] * rs_val[7:0])};
		end else if (i_op == cmad_pkg::CMAD_OP_MULS)
			mul_res = 32'($signed(rd_val[15:0]) * $signed(rs_val[15:0]));
		else
			mul_res = 32'(rd_val[15:0] * rs_val[15:0]);
	end

	logic accept;
	assign accept = i_ce && i_start && state_q == cmad_pkg::CMAD_ST_IDLE;

	// one-cycle register ops and memory sequencing
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int k = 0; k < 8; k++) regs_q[k] <= `CMAD_REG_RST;
		end else if (i_ce) begin
			if (accept && legal) begin
				unique case (i_op)
					// register or immediate move
					cmad_pkg::CMAD_OP_MOV:
						regs_q[i_rd[2:0]] <= view_wr(i_rd, i_size, rd_raw, src_b);
					cmad_pkg::CMAD_OP_ADD, cmad_pkg::CMAD_OP_SUB,
					cmad_pkg::CMAD_OP_ADDC, cmad_pkg::CMAD_OP_SUBC,
					cmad_pkg::CMAD_OP_INC, cmad_pkg::CMAD_OP_DEC,
					cmad_pkg::CMAD_OP_ADDA, cmad_pkg::CMAD_OP_SUBA:
						regs_q[i_rd[2:0]] <= view_wr(i_rd, i_size, rd_raw, alu_res);
					cmad_pkg::CMAD_OP_BCDA, cmad_pkg::CMAD_OP_BCDS:
						regs_q[i_rd[2:0]] <= view_wr(i_rd, i_size, rd_raw,
							{24'h0, bcd_res});
					// product fills next-wider view
					cmad_pkg::CMAD_OP_MULU, cmad_pkg::CMAD_OP_MULS:
						regs_q[i_rd[2:0]] <= (i_size == cmad_pkg::CMAD_SZ_B) ?
							view_wr(i_rd & 4'h7, cmad_pkg::CMAD_SZ_W, rd_raw, mul_res)
							: mul_res;
					// pre-decrement stack pointer
					cmad_pkg::CMAD_OP_PUSH:
						regs_q[`CMAD_SP_IDX] <= sp_val - size_bytes(i_size);
					default: ;
				endcase
			end else if (state_q == cmad_pkg::CMAD_ST_WRITE) begin
				if (op_q == cmad_pkg::CMAD_OP_POP ||
						op_q == cmad_pkg::CMAD_OP_MOV_LD)
					regs_q[rd_q[2:0]] <= view_wr(rd_q, size_q,
						regs_q[rd_q[2:0]], mem_wdata_q);
				// post-increment after the read completes
				if (op_q == cmad_pkg::CMAD_OP_POP)
					regs_q[`CMAD_SP_IDX] <= sp_new_q;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			flags_q <= `CMAD_FLAGS_RST;
		end else if (i_ce && accept && legal) begin
			unique case (i_op)
				// flags from adder; INC and DEC keep the old carry
				cmad_pkg::CMAD_OP_ADD, cmad_pkg::CMAD_OP_SUB,
				cmad_pkg::CMAD_OP_INC, cmad_pkg::CMAD_OP_DEC:
					flags_q <= {alu_flags[3:1], (i_op == cmad_pkg::CMAD_OP_INC ||
						i_op == cmad_pkg::CMAD_OP_DEC) ? flags_q[`CMAD_FLAG_C]
						: alu_flags[`CMAD_FLAG_C]};
				// zero flag only kept set on zero result
				cmad_pkg::CMAD_OP_ADDC, cmad_pkg::CMAD_OP_SUBC:
					flags_q <= {alu_flags[3],
						alu_flags[`CMAD_FLAG_Z] & flags_q[`CMAD_FLAG_Z],
						alu_flags[1:0]};
				cmad_pkg::CMAD_OP_BCDA, cmad_pkg::CMAD_OP_BCDS:
					flags_q <= {bcd_res[7], bcd_res == 8'h00,
						flags_q[`CMAD_FLAG_V], bcd_c};
				cmad_pkg::CMAD_OP_MOV:
					flags_q <= {view_rd(4'h0, i_size, src_b) == 32'h0 ? 2'b01 :
						{i_size == cmad_pkg::CMAD_SZ_B ? src_b[7] :
						i_size == cmad_pkg::CMAD_SZ_W ? src_b[15] : src_b[31],
						1'b0}, 1'b0, flags_q[`CMAD_FLAG_C]};
				default: ;
			endcase
		end
	end

	// memory transfer state machine for loads, stores, push, pop
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q     <= cmad_pkg::CMAD_ST_IDLE;
			op_q        <= cmad_pkg::CMAD_OP_NOP;
			size_q      <= cmad_pkg::CMAD_SZ_B;
			rd_q        <= 4'h0;
			rs_q        <= 4'h0;
			addr_q      <= `CMAD_REG_RST;
			sp_new_q    <= `CMAD_REG_RST;
			mem_req_q   <= 1'b0;
			mem_we_q    <= 1'b0;
			mem_wdata_q <= `CMAD_REG_RST;
		end else if (i_ce) begin
			unique case (state_q)
				cmad_pkg::CMAD_ST_IDLE:
					if (accept && legal && (i_op == cmad_pkg::CMAD_OP_MOV_LD ||
							i_op == cmad_pkg::CMAD_OP_MOV_ST ||
							i_op == cmad_pkg::CMAD_OP_POP ||
							i_op == cmad_pkg::CMAD_OP_PUSH)) begin
						state_q   <= cmad_pkg::CMAD_ST_MEM;
						op_q      <= i_op;
						size_q    <= i_size;
						rd_q      <= i_rd;
						rs_q      <= i_rs;
						mem_req_q <= 1'b1;
						mem_we_q  <= (i_op == cmad_pkg::CMAD_OP_MOV_ST ||
							i_op == cmad_pkg::CMAD_OP_PUSH);
						sp_new_q  <= sp_val + size_bytes(i_size);
						mem_wdata_q <= rd_val;
						unique case (i_op)
							cmad_pkg::CMAD_OP_POP:  addr_q <= sp_val;
							cmad_pkg::CMAD_OP_PUSH:
								addr_q <= sp_val - size_bytes(i_size);
							// pointer = long register plus displacement
							default: addr_q <= rs_raw + imm_val;
						endcase
					end
				cmad_pkg::CMAD_ST_MEM:
					if (i_mem_ack) begin
						mem_req_q <= 1'b0;
						mem_wdata_q <= view_rd(4'h0, size_q, i_mem_rdata);
						state_q <= mem_we_q ? cmad_pkg::CMAD_ST_IDLE
							: cmad_pkg::CMAD_ST_WRITE;
					end
				default: state_q <= cmad_pkg::CMAD_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			done_q    <= 1'b0;
			illegal_q <= 1'b0;
		end else if (i_ce) begin
			illegal_q <= accept && !legal;
			done_q <= (accept && (!legal || !(i_op == cmad_pkg::CMAD_OP_MOV_LD
				|| i_op == cmad_pkg::CMAD_OP_MOV_ST
				|| i_op == cmad_pkg::CMAD_OP_POP
				|| i_op == cmad_pkg::CMAD_OP_PUSH)))
				|| state_q == cmad_pkg::CMAD_ST_WRITE
				|| (state_q == cmad_pkg::CMAD_ST_MEM && i_mem_ack && mem_we_q);
		end
	end

	assign o_busy      = state_q != cmad_pkg::CMAD_ST_IDLE;
	assign o_done      = done_q;
	assign o_illegal   = illegal_q;
	assign o_mem_req   = mem_req_q;
	assign o_mem_we    = mem_we_q;
	assign o_mem_addr  = addr_q;
	assign o_mem_wdata = mem_wdata_q;
	assign o_mem_size  = size_q;
	assign o_flags     = flags_q;
	assign o_sp        = sp_val;
endmodule
`default_nettype wire

// >>> verif/cmad_core_props.sv
// port assertions for the move and arithmetic datapath
`timescale 1ns/100ps
`default_nettype none
module cmad_core_props (
	input wire logic                 i_clk,
	input wire logic                 i_nrst,
	input wire logic                 i_ce,
	input wire logic                 i_start,
	input wire cmad_pkg::cmad_op_t   i_op,
	input wire cmad_pkg::cmad_size_t i_size,
	input wire logic                 i_mem_ack,
	input wire logic                 o_busy,
	input wire logic                 o_done,
	input wire logic                 o_illegal,
	input wire logic                 o_mem_req,
	input wire logic                 o_mem_we,
	input wire logic          [31:0] o_mem_addr,
	input wire logic          [3:0]  o_flags,
	input wire logic          [31:0] o_sp
);
	logic        tk;
	logic        pend_q;
	logic [31:0] exp_q;
	assign tk = i_ce && i_start && !o_busy;
	// expected pointer once a pop completes
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pend_q <= 1'b0;
			exp_q  <= 32'h00000000;
		end else if (tk && i_op == cmad_pkg::CMAD_OP_POP) begin
			pend_q <= 1'b1;
			exp_q  <= o_sp + ((i_size == cmad_pkg::CMAD_SZ_W) ?
				32'h00000002 : 32'h00000004);
		end else if (o_done) begin
			pend_q <= 1'b0;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	AST_ILL_DONE: assert property (o_illegal |-> o_done)
		else $error("illegal pulse without done");
	AST_ILL_FLAGS: assert property (o_illegal |-> $stable(o_flags))
		else $error("refused op changed flags");
	AST_REQ_HOLD: assert property (o_mem_req && !i_mem_ack
		|=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
		else $error("memory request not held");
	AST_REQ_DROP: assert property (o_mem_req && i_mem_ack && i_ce
		|=> !o_mem_req)
		else $error("memory request not dropped");
	AST_REQ_BUSY: assert property (o_mem_req |-> o_busy)
		else $error("request while idle");
	AST_PUSH_SP: assert property (tk && i_op == cmad_pkg::CMAD_OP_PUSH
		&& i_size == cmad_pkg::CMAD_SZ_W |=> o_sp == $past(o_sp) - 32'h2)
		else $error("push pointer not decremented");
	AST_PUSH_REQ: assert property (tk && i_op == cmad_pkg::CMAD_OP_PUSH
		&& i_size == cmad_pkg::CMAD_SZ_W
		|-> ##[1:2] o_mem_req && o_mem_we && o_mem_addr == o_sp)
		else $error("push write not at new pointer");
	AST_POP_REQ: assert property (tk && i_op == cmad_pkg::CMAD_OP_POP
		&& i_size == cmad_pkg::CMAD_SZ_L
		|-> ##[1:2] o_mem_req && !o_mem_we && o_mem_addr == o_sp)
		else $error("pop read not at pointer");
	AST_POP_SP: assert property (pend_q && o_done && !o_illegal
		|-> o_sp == exp_q)
		else $error("pop pointer not incremented");
	AST_PSYNC: assert property (tk && (i_op == cmad_pkg::CMAD_OP_PSYNC_IN
		|| i_op == cmad_pkg::CMAD_OP_PSYNC_OUT) |-> ##[1:2] o_illegal)
		else $error("absent move accepted");
endmodule
bind cmad_core cmad_core_props u_cmad_core_props (.i_clk, .i_nrst, .i_ce,
	.i_start, .i_op, .i_size, .i_mem_ack, .o_busy, .o_done, .o_illegal,
	.o_mem_req, .o_mem_we, .o_mem_addr, .o_flags, .o_sp);
`default_nettype wire

// >>> verif/cmad_core_tb_top.sv
// self-checking testbench for the move and arithmetic datapath
`timescale 1ns/100ps
`default_nettype none
module cmad_core_tb_top;
	logic                    i_clk = 1'b0;
	logic                    i_nrst = 1'b0;
	logic                    i_ce = 1'b1;
	logic                    i_start = 1'b0;
	cmad_pkg::cmad_op_t      i_op = cmad_pkg::CMAD_OP_NOP;
	cmad_pkg::cmad_size_t    i_size = cmad_pkg::CMAD_SZ_B;
	logic             [3:0]  i_rd = 4'h0;
	logic             [3:0]  i_rs = 4'h0;
	logic             [23:0] i_imm = 24'h000000;
	cmad_pkg::cmad_imm_len_t i_imm_len = cmad_pkg::CMAD_IMM24;
	logic                    i_use_imm = 1'b0;
	logic             [1:0]  i_step = 2'h0;
	logic                    i_mem_ack = 1'b0;
	logic             [31:0] i_mem_rdata = 32'h00000000;
	logic                    o_busy;
	logic                    o_done;
	logic                    o_illegal;
	logic                    o_mem_req;
	logic                    o_mem_we;
	logic             [31:0] o_mem_addr;
	logic             [31:0] o_mem_wdata;
	cmad_pkg::cmad_size_t    o_mem_size;
	logic             [3:0]  o_flags;
	logic             [31:0] o_sp;
	logic             [31:0] ma;
	logic             [31:0] mwd;
	logic                    mwe;
	logic                    ill;
	cmad_pkg::cmad_size_t    msz;
	logic                    bsy;
	int                      fail_count = 0;
	int                      n_tests = 0;
	int                      cyc = 0;
	cmad_core u_cmad_core (.i_clk, .i_nrst, .i_ce, .i_start, .i_op, .i_size,
		.i_rd, .i_rs, .i_imm, .i_imm_len, .i_use_imm, .i_step, .i_mem_ack,
		.i_mem_rdata, .o_busy, .o_done, .o_illegal, .o_mem_req, .o_mem_we,
		.o_mem_addr, .o_mem_wdata, .o_mem_size, .o_flags, .o_sp);
	always begin
		#50;
		i_clk = ~i_clk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] e, input logic [31:0] a);
		n_tests++;
		if (a !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	// sizes: 0 byte, 1 word, 2 long; memory acked after a two-cycle stall
	task automatic op(input cmad_pkg::cmad_op_t o, input logic [1:0] s,
			input logic [3:0] d, input logic [3:0] r, input logic [23:0] m,
			input logic u, input logic [1:0] st);
		logic fin;
		@(posedge i_clk);
		#1;
		i_op = o;
		i_size = cmad_pkg::cmad_size_t'(s);
		i_rd = d;
		i_rs = r;
		i_imm = m;
		i_use_imm = u;
		i_step = st;
		i_start = 1'b1;
		ill = 1'b0;
		fin = 1'b0;
		for (int k = 0; k < 40; k++) begin
			@(posedge i_clk);
			#1;
			i_start = 1'b0;
			i_mem_ack = (o_mem_req === 1'b1) && k > 1;
			if (i_mem_ack) begin
				ma = o_mem_addr;
				mwd = o_mem_wdata;
				mwe = o_mem_we;
				msz = o_mem_size;
				bsy = o_busy;
			end
			if (o_done === 1'b1) begin
				ill = o_illegal;
				fin = 1'b1;
				break;
			end
		end
		chk(32'h1, {31'h0, fin});
	endtask
	task automatic mvi(input logic [3:0] d, input logic [1:0] s,
			input logic [23:0] m);
		op(cmad_pkg::CMAD_OP_MOV, s, d, 4'h0, m, 1'b1, 2'h0);
	endtask
	task automatic bad(input cmad_pkg::cmad_op_t o, input logic [1:0] s,
			input logic [1:0] st);
		op(o, s, 4'h0, 4'h0, 24'h000001, 1'b1, st);
		chk(32'h1, {31'h0, ill});
	endtask
	// reads a register view back through a store
	task automatic see(input logic [3:0] d, input logic [1:0] s,
			input logic [31:0] e);
		logic [31:0] mk;
		mk = (s == 2'h0) ? 32'hFF : (s == 2'h1) ? 32'hFFFF : 32'hFFFFFFFF;
		op(cmad_pkg::CMAD_OP_MOV_ST, s, d, 4'h6, 24'h000000, 1'b0, 2'h0);
		chk(e, mwd & mk);
		chk(32'h1, {31'h0, mwe});
	endtask
	task automatic t_reset();
		chk(32'h0, {28'h0, o_flags});
		chk(32'h0, o_sp);
		chk(32'h0, {31'h0, o_busy});
		$display("t_reset done");
	endtask
	task automatic t_imm();
		logic [31:0] ex [4];
		ex = '{32'h7, 32'hFF, 32'hFFFF, 32'hFFFFFF};
		for (int j = 0; j < 4; j++) begin
			i_imm_len = cmad_pkg::cmad_imm_len_t'(j);
			mvi(4'h0, 2'h2, 24'hFFFFFF);
			see(4'h0, 2'h2, ex[j]);
		end
		i_imm_len = cmad_pkg::CMAD_IMM24;
		op(cmad_pkg::CMAD_OP_MOV, 2'h2, 4'h1, 4'h0, 24'h0, 1'b0, 2'h0);
		see(4'h1, 2'h2, 32'h00FFFFFF);
		$display("t_imm done");
	endtask
	task automatic t_views();
		mvi(4'h1, 2'h2, 24'h000000);
		mvi(4'h9, 2'h0, 24'h0000A5);
		mvi(4'h9, 2'h1, 24'h001234);
		mvi(4'h1, 2'h0, 24'h00003C);
		see(4'h1, 2'h2, 32'h1234A53C);
		see(4'h9, 2'h0, 32'hA5);
		see(4'h9, 2'h1, 32'h1234);
		$display("t_views done");
	endtask
	task automatic t_add();
		mvi(4'h2, 2'h2, 24'h007FFF);
		mvi(4'h3, 2'h2, 24'h000001);
		op(cmad_pkg::CMAD_OP_ADD, 2'h1, 4'h2, 4'h3, 24'h0, 1'b0, 2'h0);
		chk(32'hA, {28'h0, o_flags});
		see(4'h2, 2'h1, 32'h8000);
		op(cmad_pkg::CMAD_OP_ADD, 2'h2, 4'h2, 4'h0, 24'h7F8000, 1'b1, 2'h0);
		see(4'h2, 2'h2, 32'h00800000);
		op(cmad_pkg::CMAD_OP_SUB, 2'h1, 4'h2, 4'h0, 24'h1, 1'b1, 2'h0);
		chk(32'h9, {28'h0, o_flags});
		see(4'h2, 2'h1, 32'hFFFF);
		bad(cmad_pkg::CMAD_OP_SUB, 2'h0, 2'h0);
		see(4'h0, 2'h0, 32'hFF);
		$display("t_add done");
	endtask
	task automatic t_carry();
		mvi(4'h4, 2'h2, 24'h0000FF);
		op(cmad_pkg::CMAD_OP_ADD, 2'h0, 4'h4, 4'h0, 24'h1, 1'b1, 2'h0);
		chk(32'h5, {28'h0, o_flags});
		op(cmad_pkg::CMAD_OP_ADDC, 2'h0, 4'h4, 4'h0, 24'h0, 1'b1, 2'h0);
		chk(32'h0, {28'h0, o_flags});
		op(cmad_pkg::CMAD_OP_SUBC, 2'h0, 4'h4, 4'h0, 24'h2, 1'b1, 2'h0);
		op(cmad_pkg::CMAD_OP_SUBC, 2'h0, 4'h4, 4'h0, 24'h0, 1'b1, 2'h0);
		see(4'h4, 2'h0, 32'hFE);
		bad(cmad_pkg::CMAD_OP_ADDC, 2'h1, 2'h0);
		$display("t_carry done");
	endtask
	task automatic t_step();
		mvi(4'h5, 2'h2, 24'h00FFFF);
		op(cmad_pkg::CMAD_OP_INC, 2'h1, 4'h5, 4'h0, 24'h0, 1'b0, 2'h1);
		see(4'h5, 2'h1, 32'h0001);
		op(cmad_pkg::CMAD_OP_DEC, 2'h0, 4'h5, 4'h0, 24'h0, 1'b0, 2'h0);
		see(4'h5, 2'h2, 32'h0);
		bad(cmad_pkg::CMAD_OP_INC, 2'h0, 2'h1);
		op(cmad_pkg::CMAD_OP_ADDA, 2'h2, 4'h5, 4'h0, 24'h0, 1'b0, 2'h2);
		op(cmad_pkg::CMAD_OP_SUBA, 2'h2, 4'h5, 4'h0, 24'h0, 1'b0, 2'h1);
		see(4'h5, 2'h2, 32'h2);
		bad(cmad_pkg::CMAD_OP_ADDA, 2'h1, 2'h0);
		$display("t_step done");
	endtask
	task automatic t_bcd();
		mvi(4'h4, 2'h0, 24'h000009);
		op(cmad_pkg::CMAD_OP_ADD, 2'h0, 4'h4, 4'h0, 24'h1, 1'b1, 2'h0);
		op(cmad_pkg::CMAD_OP_BCDA, 2'h0, 4'h4, 4'h0, 24'h0, 1'b0, 2'h0);
		see(4'h4, 2'h0, 32'h10);
		op(cmad_pkg::CMAD_OP_SUB, 2'h0, 4'h4, 4'h3, 24'h0, 1'b0, 2'h0);
		op(cmad_pkg::CMAD_OP_BCDS, 2'h0, 4'h4, 4'h0, 24'h0, 1'b0, 2'h0);
		see(4'h4, 2'h0, 32'h09);
		$display("t_bcd done");
	endtask
	task automatic t_mul();
		mvi(4'h4, 2'h2, 24'h0000FF);
		mvi(4'h3, 2'h2, 24'h000002);
		op(cmad_pkg::CMAD_OP_MULU, 2'h0, 4'h4, 4'h3, 24'h0, 1'b0, 2'h0);
		see(4'h4, 2'h1, 32'h01FE);
		mvi(4'h4, 2'h2, 24'h0000FF);
		op(cmad_pkg::CMAD_OP_MULS, 2'h0, 4'h4, 4'h3, 24'h0, 1'b0, 2'h0);
		see(4'h4, 2'h1, 32'hFFFE);
		mvi(4'h4, 2'h2, 24'h00FFFF);
		mvi(4'h3, 2'h2, 24'h00FFFF);
		op(cmad_pkg::CMAD_OP_MULU, 2'h1, 4'h4, 4'h3, 24'h0, 1'b0, 2'h0);
		see(4'h4, 2'h2, 32'hFFFE0001);
		mvi(4'h4, 2'h2, 24'h00FFFF);
		op(cmad_pkg::CMAD_OP_MULS, 2'h1, 4'h4, 4'h3, 24'h0, 1'b0, 2'h0);
		see(4'h4, 2'h2, 32'h1);
		bad(cmad_pkg::CMAD_OP_MULU, 2'h2, 2'h0);
		$display("t_mul done");
	endtask
	task automatic t_stack();
		mvi(4'h7, 2'h2, 24'h001000);
		op(cmad_pkg::CMAD_OP_PUSH, 2'h1, 4'h0, 4'h0, 24'h0, 1'b0, 2'h0);
		chk(32'h0FFE, ma);
		chk(32'h0FFE, o_sp);
		chk(32'hFFFF, mwd & 32'hFFFF);
		chk(32'h1, {30'h0, msz});
		chk(32'h1, {31'h0, bsy});
		i_mem_rdata = 32'hCAFEBABE;
		op(cmad_pkg::CMAD_OP_POP, 2'h2, 4'h1, 4'h0, 24'h0, 1'b0, 2'h0);
		chk(32'h0FFE, ma);
		chk(32'h2, {30'h0, msz});
		chk(32'h1002, o_sp);
		see(4'h1, 2'h2, 32'hCAFEBABE);
		bad(cmad_pkg::CMAD_OP_PUSH, 2'h0, 2'h0);
		$display("t_stack done");
	endtask
	task automatic t_load();
		mvi(4'h6, 2'h2, 24'h000100);
		i_mem_rdata = 32'h1234565A;
		op(cmad_pkg::CMAD_OP_MOV_LD, 2'h0, 4'h2, 4'h6, 24'h10, 1'b0, 2'h0);
		chk(32'h0110, ma);
		chk(32'h0, {31'h0, mwe});
		see(4'h2, 2'h0, 32'h5A);
		bad(cmad_pkg::CMAD_OP_PSYNC_IN, 2'h0, 2'h0);
		bad(cmad_pkg::CMAD_OP_PSYNC_OUT, 2'h0, 2'h0);
		$display("t_load done");
	endtask
	// a request held while the clock enable is low must not be taken
	task automatic t_ce();
		mvi(4'h3, 2'h2, 24'h000055);
		@(posedge i_clk);
		#1;
		i_ce = 1'b0;
		i_op = cmad_pkg::CMAD_OP_MOV;
		i_imm = 24'h0000AA;
		i_start = 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		chk(32'h0, {31'h0, o_done});
		i_start = 1'b0;
		i_ce = 1'b1;
		see(4'h3, 2'h2, 32'h55);
		$display("t_ce done");
	endtask
	initial begin
		repeat (20) @(posedge i_clk);
		#1;
		i_nrst = 1'b1;
		t_reset();
		t_imm();
		t_views();
		t_add();
		t_carry();
		t_step();
		t_bcd();
		t_mul();
		t_stack();
		t_load();
		t_ce();
		print_verdict();
	end
endmodule
`default_nettype wire
